// ==== inc/cfl_pkg.sv ====
// constants for the critical fault log configuration block
`default_nettype none
package cfl_pkg;
	localparam int unsigned NUM_INPUTS = 12;
	localparam logic [7:0] ADDR_CONTENT_SEL = 8'h47;
	localparam logic [7:0] ADDR_UV_EN_LOW   = 8'h48;
	localparam logic [7:0] ADDR_UV_OV_EN    = 8'h49;
	localparam logic [7:0] ADDR_OV_EN_HIGH  = 8'h4a;
	localparam logic [7:0] ADDR_EW_EN_LOW   = 8'h4b;
	localparam logic [7:0] ADDR_EW_EN_HIGH  = 8'h4c;
	localparam logic [7:0] ADDR_UNLOCK      = 8'h5d;
	localparam int unsigned UNLOCK_BIT      = 1;
	localparam int unsigned LOCK_STATUS_BIT = 0;
	localparam logic [7:0] RST_CONTENT_SEL  = 8'h00;
	localparam logic [7:0] RST_ENABLE       = 8'h00;
	localparam logic [7:0] MASK_CONTENT_SEL = 8'h03;
	localparam logic [7:0] MASK_EW_HIGH     = 8'h0f;
	typedef enum logic [1:0] {
		CFL_SAVE_BOTH  = 2'b00,
		CFL_SAVE_FLAGS = 2'b01,
		CFL_SAVE_ADC   = 2'b10,
		CFL_SAVE_NONE  = 2'b11
	} cfl_content_e;
endpackage
`default_nettype wire

// ==== hdl/cfl_trigger.sv ====
// maps per-input fault conditions through their enable bits
`timescale 1ns/100ps
`default_nettype none
module cfl_trigger (
	// fault conditions, bit n is monitored input n+1
	input  wire logic [11:0] uv_in,
	input  wire logic [11:0] ov_in,
	input  wire logic [11:0] ew_in,
	// enable registers
	input  wire logic [7:0]  uv_en_low_in,
	input  wire logic [7:0]  uv_ov_en_in,
	input  wire logic [7:0]  ov_en_high_in,
	input  wire logic [7:0]  ew_en_low_in,
	input  wire logic [7:0]  ew_en_high_in,
	// result
	output logic      [11:0] failed_out,
	output logic             any_out
);
	logic [11:0] uv_en;
	logic [11:0] ov_en;
	logic [11:0] ew_en;

	assign uv_en = {uv_ov_en_in[3:0], uv_en_low_in};   // RL3 RL4
	assign ov_en = {ov_en_high_in, uv_ov_en_in[7:4]};  // RL5 RL6 RL7
	assign ew_en = {ew_en_high_in[3:0], ew_en_low_in}; // RL10
	// disabled conditions never reach the logger
	assign failed_out = (uv_in & uv_en) | (ov_in & ov_en) | (ew_in & ew_en); // RL11
	assign any_out = |failed_out; // RL11
endmodule
`default_nettype wire

// ==== hdl/cfl_top.sv ====
// critical fault log configuration registers and log trigger
`timescale 1ns/100ps
`default_nettype none
// Function
// RL1: codes 00/01/10 select flags+adc, flags, adc
// RL2: code 11 saves nothing, logger off
// RL3: first enable bits gate undervoltage inputs 1-8
// RL4: second enable bits 0-3 gate undervoltage 9-12
// RL5: second enable bits 4-7 gate overvoltage 1-4
// RL6: third enable bits 0-6 gate overvoltage 5-11
// RL7: third enable bit 7 gates overvoltage 12
// RL8: enabled fault shuts supplies, starts log transfer
// RL9: stored log locks; write unlock bit to rearm
// RL10: early-warning enable bits also trigger logs
// RL11: only enabled conditions trigger; unused bits read zero
module cfl_top (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	// register port from the serial configuration engine
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             reg_ack_out,
	// conditions from the converter compare, same clock
	input  wire logic [11:0] uv_fault_in,
	input  wire logic [11:0] ov_fault_in,
	input  wire logic [11:0] ew_fault_in,
	// supply control and nonvolatile log request
	output logic             supply_shutdown_out,
	output logic             log_start_out,
	output logic             log_save_flags_out,
	output logic             log_save_adc_out,
	output logic      [11:0] log_failed_lines_out,
	output logic             log_locked_out
);
	logic [7:0]  content_sel_reg;
	logic [7:0]  uv_en_low_reg;
	logic [7:0]  uv_ov_en_reg;
	logic [7:0]  ov_en_high_reg;
	logic [7:0]  ew_en_low_reg;
	logic [7:0]  ew_en_high_reg;
	logic [11:0] failed;
	logic        any_fault;
	logic        unlock_wr;
	logic        log_go;
	logic [7:0]  rdata_next;
	cfl_pkg::cfl_content_e mode;

	function automatic logic wr_hit(input logic [7:0] a);
		wr_hit = reg_wr_in && (reg_addr_in == a);
	endfunction

	cfl_trigger u_trigger (
		.uv_in         (uv_fault_in),
		.ov_in         (ov_fault_in),
		.ew_in         (ew_fault_in),
		.uv_en_low_in  (uv_en_low_reg),
		.uv_ov_en_in   (uv_ov_en_reg),
		.ov_en_high_in (ov_en_high_reg),
		.ew_en_low_in  (ew_en_low_reg),
		.ew_en_high_in (ew_en_high_reg),
		.failed_out    (failed),
		.any_out       (any_fault)
	);

	assign mode = cfl_pkg::cfl_content_e'(content_sel_reg[1:0]);
	assign unlock_wr = wr_hit(cfl_pkg::ADDR_UNLOCK) && reg_wdata_in[cfl_pkg::UNLOCK_BIT];
	// a locked log or a disabled logger never starts a transfer
	assign log_go = any_fault && !log_locked_out && (mode != cfl_pkg::CFL_SAVE_NONE); // RL2 RL9

	// configuration registers; unused bits are stored as zero
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			content_sel_reg <= cfl_pkg::RST_CONTENT_SEL;
			uv_en_low_reg   <= cfl_pkg::RST_ENABLE;
			uv_ov_en_reg    <= cfl_pkg::RST_ENABLE;
			ov_en_high_reg  <= cfl_pkg::RST_ENABLE;
			ew_en_low_reg   <= cfl_pkg::RST_ENABLE;
			ew_en_high_reg  <= cfl_pkg::RST_ENABLE;
		end else begin
			if (wr_hit(cfl_pkg::ADDR_CONTENT_SEL)) begin
				content_sel_reg <= reg_wdata_in & cfl_pkg::MASK_CONTENT_SEL; // RL11
			end
			if (wr_hit(cfl_pkg::ADDR_UV_EN_LOW)) begin
				uv_en_low_reg <= reg_wdata_in;
			end
			if (wr_hit(cfl_pkg::ADDR_UV_OV_EN)) begin
				uv_ov_en_reg <= reg_wdata_in;
			end
			if (wr_hit(cfl_pkg::ADDR_OV_EN_HIGH)) begin
				ov_en_high_reg <= reg_wdata_in;
			end
			if (wr_hit(cfl_pkg::ADDR_EW_EN_LOW)) begin
				ew_en_low_reg <= reg_wdata_in;
			end
			if (wr_hit(cfl_pkg::ADDR_EW_EN_HIGH)) begin
				ew_en_high_reg <= reg_wdata_in & cfl_pkg::MASK_EW_HIGH; // RL11
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = 8'h00;
		unique case (reg_addr_in)
			cfl_pkg::ADDR_CONTENT_SEL: rdata_next = content_sel_reg;
			cfl_pkg::ADDR_UV_EN_LOW:   rdata_next = uv_en_low_reg;
			cfl_pkg::ADDR_UV_OV_EN:    rdata_next = uv_ov_en_reg;
			cfl_pkg::ADDR_OV_EN_HIGH:  rdata_next = ov_en_high_reg;
			cfl_pkg::ADDR_EW_EN_LOW:   rdata_next = ew_en_low_reg;
			cfl_pkg::ADDR_EW_EN_HIGH:  rdata_next = ew_en_high_reg;
			cfl_pkg::ADDR_UNLOCK:      rdata_next[cfl_pkg::LOCK_STATUS_BIT] = log_locked_out;
			default:                   rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 8'h00;
			reg_ack_out   <= 1'b0;
		end else begin
			reg_ack_out <= reg_rd_in || reg_wr_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_next;
			end
		end
	end

	// shutdown holds until reset; restarting supplies is left to the sequencer reset
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			supply_shutdown_out <= 1'b0;
		end else if (any_fault) begin
			supply_shutdown_out <= 1'b1; // RL8
		end
	end

	// lock: a new log wins over an unlock in the same cycle
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			log_locked_out <= 1'b0;
		end else if (log_go) begin
			log_locked_out <= 1'b1; // RL9
		end else if (unlock_wr) begin
			log_locked_out <= 1'b0; // RL9
		end
	end

	// one-cycle transfer request with the content selection
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			log_start_out        <= 1'b0;
			log_save_flags_out   <= 1'b0;
			log_save_adc_out     <= 1'b0;
			log_failed_lines_out <= 12'h000;
		end else begin
			log_start_out <= log_go; // RL8
			if (log_go) begin
				log_save_flags_out   <= (mode == cfl_pkg::CFL_SAVE_BOTH)
					|| (mode == cfl_pkg::CFL_SAVE_FLAGS); // RL1
				log_save_adc_out     <= (mode == cfl_pkg::CFL_SAVE_BOTH)
					|| (mode == cfl_pkg::CFL_SAVE_ADC); // RL1
				log_failed_lines_out <= failed;
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	sequence s_fault_open;
		any_fault && !log_locked_out && mode != cfl_pkg::CFL_SAVE_NONE;
	endsequence

	// second step of a log: the request pulse and the lock rise together
	sequence s_log_taken;
		log_start_out && log_locked_out;
	endsequence

	// every check except a_unused_zero looks one cycle after the cause, since all results are registered
	a_flags_mode: assert property ((s_fault_open and mode == cfl_pkg::CFL_SAVE_FLAGS) // RL1
		|=> s_log_taken ##0 (log_save_flags_out && !log_save_adc_out))
		else $error("flags-only mode sent wrong content");
	a_adc_mode: assert property ((s_fault_open and mode == cfl_pkg::CFL_SAVE_ADC) // RL1
		|=> s_log_taken ##0 (!log_save_flags_out && log_save_adc_out))
		else $error("adc-only mode sent wrong content");
	a_both_mode: assert property ((s_fault_open and mode == cfl_pkg::CFL_SAVE_BOTH) // RL1
		|=> s_log_taken ##0 (log_save_flags_out && log_save_adc_out))
		else $error("both mode sent wrong content");
	a_logger_off: assert property (mode == cfl_pkg::CFL_SAVE_NONE && !log_locked_out // RL2
		|=> !log_start_out && !log_locked_out)
		else $error("log started while logger off");
	a_uv_low: assert property (|(uv_fault_in[7:0] & uv_en_low_reg) |=> supply_shutdown_out) // RL3
		else $error("enabled undervoltage did not shut down");
	a_uv_high: assert property (|(uv_fault_in[11:8] & uv_ov_en_reg[3:0]) // RL4
		|=> supply_shutdown_out)
		else $error("enabled high undervoltage did not shut down");
	a_ov_low: assert property (|(ov_fault_in[3:0] & uv_ov_en_reg[7:4]) // RL5
		|=> supply_shutdown_out)
		else $error("enabled low overvoltage did not shut down");
	a_ov_high: assert property (|(ov_fault_in[11:4] & ov_en_high_reg) |=> supply_shutdown_out) // RL6 RL7
		else $error("enabled high overvoltage did not shut down");
	a_ew_trigger: assert property (|(ew_fault_in & {ew_en_high_reg[3:0], ew_en_low_reg}) // RL10
		|=> supply_shutdown_out)
		else $error("enabled early warning did not shut down");
	a_shut_hold: assert property (supply_shutdown_out |=> supply_shutdown_out) // RL8
		else $error("supply shutdown released before reset");
	a_fail_capture: assert property (s_fault_open // RL8
		|=> log_failed_lines_out == $past(failed))
		else $error("failed lines not captured");
	a_lock_hold: assert property (log_locked_out && !unlock_wr |=> log_locked_out) // RL9
		else $error("lock released without unlock");
	a_lock_refuse: assert property (log_locked_out |=> !log_start_out) // RL9
		else $error("log started while locked");
	a_unlock_clear: assert property (unlock_wr && !log_go |=> !log_locked_out) // RL9
		else $error("unlock write did not release the lock");
	a_unused_zero: assert property (content_sel_reg[7:2] == 6'h00 // RL11
		&& ew_en_high_reg[7:4] == 4'h0)
		else $error("unused register bits not zero");
	a_quiet_idle: assert property (!any_fault |=> !log_start_out) // RL11
		else $error("log started without enabled fault");
endmodule
`default_nettype wire

// ==== tb/test_critical_fault_log_config.sv ====
// self-checking bench for the critical fault log configuration block
`timescale 1ns/100ps
`default_nettype none
module test_critical_fault_log_config;
	logic        clk_sys_in, rstn_in, reg_wr_in, reg_rd_in, reg_ack_out;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic        supply_shutdown_out, log_start_out, log_save_flags_out;
	logic        log_save_adc_out, log_locked_out;
	logic [11:0] uv_fault_in, ov_fault_in, ew_fault_in, log_failed_lines_out;
	logic [11:0] ue, oe, ee;
	logic [8:0]  aq[$];
	logic [13:0] lq[$];
	logic [1:0]  md;
	logic [7:0]  adr[8] = '{8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h5d, 8'h50};
	int          n_fail, checked, seed, i;
	cfl_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
		.uv_fault_in(uv_fault_in), .ov_fault_in(ov_fault_in), .ew_fault_in(ew_fault_in),
		.supply_shutdown_out(supply_shutdown_out), .log_start_out(log_start_out),
		.log_save_flags_out(log_save_flags_out), .log_save_adc_out(log_save_adc_out),
		.log_failed_lines_out(log_failed_lines_out), .log_locked_out(log_locked_out));
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	task chk(input string nm, input logic [13:0] e, input logic [13:0] s);
		checked++;
		if (e !== s) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// e[8] marks a read whose data is compared when the ack shows
	task acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
		aq.push_back(e);
		@(posedge clk_sys_in);
		#1 reg_wr_in = wr;
		reg_rd_in = !wr;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge clk_sys_in);
		#1 reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
	endtask
	// disabled bits carry random noise that must be ignored
	task flt(input logic lg, input logic [13:0] e);
		if (lg) lq.push_back(e);
		@(posedge clk_sys_in);
		#1 uv_fault_in = ue | (12'($random(seed)) & ~ue);
		ov_fault_in = oe | (12'($random(seed)) & ~oe);
		ew_fault_in = ee | (12'($random(seed)) & ~ee);
		repeat (2) @(posedge clk_sys_in);
		#1 uv_fault_in = 12'h000;
		ov_fault_in = 12'h000;
		ew_fault_in = 12'h000;
		@(negedge clk_sys_in);
	endtask
	// mid-run reset, entered off the edge after any pending ack was seen
	task rst;
		@(posedge clk_sys_in);
		#1 rstn_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1 rstn_in = 1'b1;
	endtask
	task close_out;
		$display("checks %0d errors %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge clk_sys_in) begin
		if (rstn_in === 1'b1 && reg_ack_out === 1'b1) begin
			if (aq.size() == 0) chk("ack", 14'h0000, 14'h0001);
			else if (aq[0][8]) chk("rdata", {5'h00, aq.pop_front()}, {6'h01, reg_rdata_out});
			else void'(aq.pop_front());
		end
		if (rstn_in === 1'b1 && log_start_out !== 1'b0) begin
			if (lq.size() == 0) chk("log_start", 14'h0000, 14'h0001);
			else chk("log", lq.pop_front(),
				{log_save_flags_out, log_save_adc_out, log_failed_lines_out});
		end
	end
	initial begin
		#100000;
		n_fail++;
		close_out;
	end
	initial begin
		seed = 70363;
		n_fail = 0;
		checked = 0;
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 18'h00000;
		{uv_fault_in, ov_fault_in, ew_fault_in} = 36'h000000000;
		{ue, oe, ee} = 36'h000000000;
		rstn_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1 rstn_in = 1'b1;
		foreach (adr[k])
			acc(1'b0, adr[k], 8'h00, 9'h100);
		acc(1'b1, 8'h47, 8'hff, 9'h000);
		acc(1'b0, 8'h47, 8'h00, 9'h103);
		acc(1'b1, 8'h4c, 8'hff, 9'h000);
		acc(1'b0, 8'h4c, 8'h00, 9'h10f);
		acc(1'b1, 8'h50, 8'hff, 9'h000);
		acc(1'b0, 8'h50, 8'h00, 9'h100);
		// one enable bit at a time, every log code in turn
		for (i = 0; i < 36; i++) begin
			rst();
			md = 2'(i);
			ue = (i < 12) ? 12'h001 << (i % 12) : 12'h000;
			oe = (i >= 12 && i < 24) ? 12'h001 << (i % 12) : 12'h000;
			ee = (i >= 24) ? 12'h001 << (i % 12) : 12'h000;
			acc(1'b1, 8'h47, {6'h00, md}, 9'h000);
			acc(1'b1, 8'h48, ue[7:0], 9'h000);
			acc(1'b1, 8'h49, {oe[3:0], ue[11:8]}, 9'h000);
			acc(1'b1, 8'h4a, oe[11:4], 9'h000);
			acc(1'b1, 8'h4b, ee[7:0], 9'h000);
			acc(1'b1, 8'h4c, {4'h0, ee[11:8]}, 9'h000);
			chk("shutdown", 14'h0000, {13'h0000, supply_shutdown_out});
			flt(md != 2'b11, {~md[1], ~md[0], ue | oe | ee});
			chk("shutdown", 14'h0001, {13'h0000, supply_shutdown_out});
			chk("locked", {13'h0000, md != 2'b11}, {13'h0000, log_locked_out});
			acc(1'b0, 8'h5d, 8'h00, {8'h80, md != 2'b11});
			flt(1'b0, 14'h0000);
			acc(1'b1, 8'h5d, 8'h02, 9'h000);
			acc(1'b0, 8'h5d, 8'h00, 9'h100);
			chk("locked", 14'h0000, {13'h0000, log_locked_out});
		end
		repeat (4) @(posedge clk_sys_in);
		chk("pending", 14'h0000, 14'(aq.size() + lq.size()));
		close_out;
	end
endmodule
`default_nettype wire
